//--- rtl/spi_link_pkg.sv
// Shared constants for the serial register-access link
package spi_link_pkg;
   // Clock and link timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SCK_PERIOD_NS = 800;
   localparam int unsigned SCK_HALF_CYC  = (SCK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                           / (2 * CLK_PERIOD_NS);
   // Frame layout
   localparam int unsigned BYTE_BITS     = 8;
   localparam int unsigned ADDR_BITS     = 7;
   localparam int unsigned WNR_POS       = 7;
   localparam logic        WNR_WRITE     = 1'b1;
   // Address of the data queue; held fixed during a frame
   localparam logic [6:0]  FIFO_ADDR_DEF = 7'h00;
   // Reset values
   localparam logic [7:0]  BYTE_RST      = 8'h00;
   localparam logic [2:0]  BIT_RST       = 3'h0;
endpackage

//--- rtl/spi_link_if.sv
// Four-wire serial link between the master end and the register slave
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   // Wires driven by the master
   logic sck;
   logic nss;
   logic mosi;
   // Slave data output and its enable (low while the slave drives)
   logic miso_o;
   logic miso_oe_n;
   // Resolved data line; an idle line is pulled high
   logic miso;

   // Wire level from the slave's enable
   assign miso = miso_oe_n ? 1'b1 : miso_o;

   modport slave (
      input  sck,
      input  nss,
      input  mosi,
      output miso_o,
      output miso_oe_n
   );
   modport master (
      output sck,
      output nss,
      output mosi,
      input  miso
   );
endinterface
`default_nettype wire

//--- rtl/spi_reg_slave.sv
// Register-access serial slave: the device end of the link
//
// Contract
// - Full duplex, clock idle low, phase zero
// - Slave only, never drives clock or select
// - Single access: address byte then data byte
// - Burst: address increments after every data byte except at the queue address
// - Queue address is held for whole frame
// - Master shifts on fall, slave samples rise
// - Slave updates data out on falling edge
// - Select low starts; output released while high
// - First byte: write flag, 7-bit address, MSB first
// - Data bytes shifted most significant bit first
// - Select rise ends frame; next byte is address
// - Write returns register's previous value
`timescale 1ns/1ps
`default_nettype none
module spi_reg_slave
   import spi_link_pkg::*;
#(
   parameter logic [6:0] FIFO_ADDR = FIFO_ADDR_DEF
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Link
   spi_link_if.slave       link,
   // Register file side
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);

   // Idle until selected, then one address byte, then data bytes
   typedef enum {S_IDLE, S_ADDR, S_DATA} slv_state_e;

   // Next register address: the queue address never advances, so a long
   // queue transfer keeps hitting the same location
   function automatic logic [6:0] next_addr(input logic [6:0] a);
      next_addr = (a == FIFO_ADDR) ? a : 7'(a + 7'h01);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // The link clock is just another pin here; an edge is acted on three cycles
   // after it moves, so three system clocks per half period is the least usable
   logic [1:0] sck_sync_r, nss_sync_r, mosi_sync_r;
   logic [1:0] sck_sync_nxt, nss_sync_nxt, mosi_sync_nxt;
   logic       sck_prev_r, sck_prev_nxt;
   logic       sck_s, nss_s, mosi_s, sck_rise, sck_fall;

   // Two flops per pin, plus one for edge finding
   always_comb begin
      sck_sync_nxt  = {sck_sync_r[0], link.sck};
      nss_sync_nxt  = {nss_sync_r[0], link.nss};
      mosi_sync_nxt = {mosi_sync_r[0], link.mosi};
      sck_prev_nxt  = sck_sync_r[1];
   end

   // Synchroniser registers; select resets to its idle high level
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_sync_r  <= 2'h0;
         nss_sync_r  <= 2'h3;
         mosi_sync_r <= 2'h0;
         sck_prev_r  <= 1'b0;
      end else begin
         sck_sync_r  <= sck_sync_nxt;
         nss_sync_r  <= nss_sync_nxt;
         mosi_sync_r <= mosi_sync_nxt;
         sck_prev_r  <= sck_prev_nxt;
      end
   end

   // Synchronised levels and clock edges
   assign sck_s    = sck_sync_r[1];
   assign nss_s    = nss_sync_r[1];
   assign mosi_s   = mosi_sync_r[1];
   assign sck_rise = sck_s & ~sck_prev_r;
   assign sck_fall = ~sck_s & sck_prev_r;

   ////////////////////////////////////////////////////////////////////////
   // Frame engine
   slv_state_e state_r, state_nxt;
   logic [2:0] bit_cnt_r, bit_cnt_nxt;
   logic [6:0] shin_r, shin_nxt;
   logic [6:0] addr_r, addr_nxt;
   logic       wnr_r, wnr_nxt;
   logic [7:0] tx_r, tx_nxt;
   logic       miso_r, miso_nxt;
   logic       oe_n_r, oe_n_nxt;
   logic       adv_r, adv_nxt;
   logic       fetch_r, fetch_nxt;
   logic       wr_r, wr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] byte_in;

   // Completed byte, MSB received first
   assign byte_in = {shin_r, mosi_s};

   // Next state of the frame engine
   // Each byte ends on its eighth rise; the write, the address step and the
   // fetch follow in that order before the next falling edge is acted on
   always_comb begin
      state_nxt   = state_r;
      bit_cnt_nxt = bit_cnt_r;
      shin_nxt    = shin_r;
      addr_nxt    = addr_r;
      wnr_nxt     = wnr_r;
      tx_nxt      = tx_r;
      miso_nxt    = miso_r;
      oe_n_nxt    = nss_s;
      adv_nxt     = 1'b0;
      fetch_nxt   = 1'b0;
      wr_nxt      = 1'b0;
      wdata_nxt   = wdata_r;
      if (nss_s) begin
         // Frame ended: next byte will be an address
         state_nxt   = S_IDLE;
         bit_cnt_nxt = BIT_RST;
         tx_nxt      = BYTE_RST;
         miso_nxt    = 1'b0;
      end else begin
         if (state_r == S_IDLE) begin
            state_nxt   = S_ADDR;
            bit_cnt_nxt = BIT_RST;
         end
         // Step the register address, then fetch its contents
         if (adv_r) begin
            addr_nxt  = next_addr(addr_r);
            fetch_nxt = 1'b1;
         end
         // Load the outgoing byte before its first falling edge
         // The fetch lands just after a rise, so it never meets a fall
         if (fetch_r) begin
            tx_nxt = reg_rdata;
         end else if (sck_fall) begin
            miso_nxt = tx_r[BYTE_BITS-1];
            tx_nxt   = {tx_r[6:0], 1'b0};
         end
         if (sck_rise && state_r != S_IDLE) begin
            shin_nxt    = byte_in[6:0];
            bit_cnt_nxt = 3'(bit_cnt_r + 3'h1);
            if (bit_cnt_r == 3'(BYTE_BITS - 1)) begin
               if (state_r == S_ADDR) begin
                  // Address byte: flag then 7-bit address
                  wnr_nxt   = byte_in[WNR_POS];
                  addr_nxt  = byte_in[ADDR_BITS-1:0];
                  fetch_nxt = 1'b1;
                  state_nxt = S_DATA;
               end else begin
                  // Data byte: write it, then move on
                  wr_nxt    = (wnr_r == WNR_WRITE);
                  wdata_nxt = byte_in;
                  adv_nxt   = 1'b1;
               end
            end
         end
      end
   end

   // Frame engine registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r   <= S_IDLE;
         bit_cnt_r <= BIT_RST;
         shin_r    <= 7'h00;
         addr_r    <= 7'h00;
         wnr_r     <= 1'b0;
         tx_r      <= BYTE_RST;
         miso_r    <= 1'b0;
         oe_n_r    <= 1'b1;
         adv_r     <= 1'b0;
         fetch_r   <= 1'b0;
         wr_r      <= 1'b0;
         wdata_r   <= BYTE_RST;
      end else begin
         state_r   <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shin_r    <= shin_nxt;
         addr_r    <= addr_nxt;
         wnr_r     <= wnr_nxt;
         tx_r      <= tx_nxt;
         miso_r    <= miso_nxt;
         oe_n_r    <= oe_n_nxt;
         adv_r     <= adv_nxt;
         fetch_r   <= fetch_nxt;
         wr_r      <= wr_nxt;
         wdata_r   <= wdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs; the slave only answers, it never drives clock or select
   // A read fetch doubles as the queue pop, so the last byte of a read burst
   // pops one entry that is never shifted out
   assign link.miso_o    = miso_r;
   assign link.miso_oe_n = oe_n_r;
   assign reg_addr       = addr_r;
   assign reg_wdata      = wdata_r;
   assign reg_wr         = wr_r;
   assign reg_rd         = fetch_r & ~wnr_r;   // Pop strobe on reads only

endmodule
`default_nettype wire

//--- rtl/spi_reg_master.sv
// Serial link master: drives clock, select and command frames
`timescale 1ns/1ps
`default_nettype none
module spi_reg_master
   import spi_link_pkg::*;
#(
   parameter int unsigned HALF_CYC = SCK_HALF_CYC
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   // Link
   spi_link_if.master      link,
   // Command
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire logic       cmd_wnr,
   input  wire logic [6:0] cmd_addr,
   input  wire logic [7:0] cmd_len,
   // Write data, taken on wr_take
   input  wire logic [7:0] wr_data,
   output logic            wr_take,
   // Read data
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output logic            busy
);

   typedef enum {M_IDLE, M_LOW, M_HIGH, M_TAIL} mst_state_e;

   ////////////////////////////////////////////////////////////////////////
   // Data line synchroniser
   logic [1:0] miso_sync_r;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         miso_sync_r <= 2'h0;
      end else begin
         miso_sync_r <= {miso_sync_r[0], link.miso};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frame sequencer with half-period divider
   mst_state_e state_r, state_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        sck_r, sck_nxt;
   logic        nss_r, nss_nxt;
   logic        mosi_r, mosi_nxt;
   logic [7:0]  sh_r, sh_nxt;
   logic [6:0]  rx_r, rx_nxt;
   logic [2:0]  bit_r, bit_nxt;
   logic [7:0]  left_r, left_nxt;
   logic        wnr_r, wnr_nxt;
   logic        first_r, first_nxt;
   logic [7:0]  rd_data_r, rd_data_nxt;
   logic        rd_valid_r, rd_valid_nxt;
   logic        tick, byte_end;
   logic [7:0]  remain, next_byte;

   // Divider tick and end-of-byte helpers
   assign tick      = (cnt_r == 16'(HALF_CYC - 1));
   assign byte_end  = tick && state_r == M_HIGH && bit_r == 3'(BYTE_BITS - 1);
   assign remain    = first_r ? left_r : 8'(left_r - 8'h01);
   assign next_byte = wnr_r ? wr_data : BYTE_RST;

   // Next state of the sequencer
   always_comb begin
      state_nxt    = state_r;
      cnt_nxt      = tick ? 16'h0000 : 16'(cnt_r + 16'h0001);
      sck_nxt      = sck_r;
      nss_nxt      = nss_r;
      mosi_nxt     = mosi_r;
      sh_nxt       = sh_r;
      rx_nxt       = rx_r;
      bit_nxt      = bit_r;
      left_nxt     = left_r;
      wnr_nxt      = wnr_r;
      first_nxt    = first_r;
      rd_data_nxt  = rd_data_r;
      rd_valid_nxt = 1'b0;
      case (state_r)
         M_IDLE: begin
            cnt_nxt = 16'h0000;
            if (cmd_valid) begin
               nss_nxt   = 1'b0;
               sh_nxt    = {cmd_wnr, cmd_addr};
               mosi_nxt  = cmd_wnr;
               wnr_nxt   = cmd_wnr;
               left_nxt  = cmd_len;
               first_nxt = 1'b1;
               bit_nxt   = BIT_RST;
               state_nxt = M_LOW;
            end
         end
         M_LOW: begin
            if (tick) begin
               sck_nxt   = 1'b1;
               state_nxt = M_HIGH;
            end
         end
         M_HIGH: begin
            if (tick) begin
               // Capture at end of high phase, then fall and shift
               rx_nxt  = {rx_r[5:0], miso_sync_r[1]};
               sck_nxt = 1'b0;
               if (byte_end) begin
                  if (!first_r && !wnr_r) begin
                     rd_data_nxt  = {rx_r, miso_sync_r[1]};
                     rd_valid_nxt = 1'b1;
                  end
                  left_nxt  = remain;
                  first_nxt = 1'b0;
                  bit_nxt   = BIT_RST;
                  if (remain == 8'h00) begin
                     state_nxt = M_TAIL;
                  end else begin
                     sh_nxt    = next_byte;
                     mosi_nxt  = next_byte[BYTE_BITS-1];
                     state_nxt = M_LOW;
                  end
               end else begin
                  bit_nxt   = 3'(bit_r + 3'h1);
                  sh_nxt    = {sh_r[6:0], 1'b0};
                  mosi_nxt  = sh_r[BYTE_BITS-2];
                  state_nxt = M_LOW;
               end
            end
         end
         default: begin
            if (tick) begin
               nss_nxt   = 1'b1;
               mosi_nxt  = 1'b0;
               state_nxt = M_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_r    <= M_IDLE;
         cnt_r      <= 16'h0000;
         sck_r      <= 1'b0;
         nss_r      <= 1'b1;
         mosi_r     <= 1'b0;
         sh_r       <= BYTE_RST;
         rx_r       <= 7'h00;
         bit_r      <= BIT_RST;
         left_r     <= BYTE_RST;
         wnr_r      <= 1'b0;
         first_r    <= 1'b0;
         rd_data_r  <= BYTE_RST;
         rd_valid_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         sck_r      <= sck_nxt;
         nss_r      <= nss_nxt;
         mosi_r     <= mosi_nxt;
         sh_r       <= sh_nxt;
         rx_r       <= rx_nxt;
         bit_r      <= bit_nxt;
         left_r     <= left_nxt;
         wnr_r      <= wnr_nxt;
         first_r    <= first_nxt;
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   // Outputs
   assign link.sck  = sck_r;
   assign link.nss  = nss_r;
   assign link.mosi = mosi_r;
   assign cmd_ready = (state_r == M_IDLE);
   assign wr_take   = byte_end && remain != 8'h00 && wnr_r;
   assign rd_data   = rd_data_r;
   assign rd_valid  = rd_valid_r;
   assign busy      = (state_r != M_IDLE);

endmodule
`default_nettype wire

//--- test/spi_link_checker.sv
// Protocol assertions on the wires of the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_link_checker #(
   parameter int unsigned HALF_CYC = 4
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Link wires
   input wire logic sck,
   input wire logic nss,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   input wire logic miso
);
   logic       sck_d_r;
   logic       sck_d_nxt;
   logic [7:0] hcnt_r;
   logic [7:0] hcnt_nxt;
   // Cycles since the clock line last changed, saturating
   always_comb begin
      sck_d_nxt = sck;
      hcnt_nxt  = (sck != sck_d_r) ? 8'h00 : ((&hcnt_r) ? hcnt_r : hcnt_r + 8'h01);
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_d_r <= 1'b0;
         hcnt_r  <= 8'h00;
      end else begin
         sck_d_r <= sck_d_nxt;
         hcnt_r  <= hcnt_nxt;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_sck_idle_low: assert property (nss |-> !sck)
      else $error("clock not low outside a frame");
   a_miso_released: assert property (nss [*4] |-> miso_oe_n)
      else $error("data out driven while deselected");
   a_miso_driven: assert property ($fell(nss) |-> ##[1:4] !miso_oe_n)
      else $error("data out not driven after select");
   a_mosi_on_fall: assert property ($changed(mosi) |-> !sck)
      else $error("master data changed while clock high");
   a_miso_stable: assert property (!nss && $fell(sck) |-> $stable(miso_o))
      else $error("slave data moved before capture");
   a_frame_end: assert property ($rose(nss) |-> !sck && !$past(sck, 4))
      else $error("select raised inside a bit");
   a_half_period: assert property (sck_d_r && !sck |-> hcnt_r == 8'(HALF_CYC - 1))
      else $error("clock high phase has wrong length");
   a_frame_start: assert property ($fell(nss) |-> !sck [*4] ##1 sck)
      else $error("first clock rise misplaced");
   a_select_held: assert property (!nss && sck |=> !nss)
      else $error("select raised during high clock");
   // Main scenarios
   c_frame: cover property ($rose(nss));
   c_drive: cover property (!miso_oe_n && !miso);
   c_bit: cover property (!nss && $fell(sck));
endmodule
`default_nettype wire

//--- test/spi_register_access_slave_tb_top.sv
// Bench joining master and slave ends across the link
`timescale 1ns/1ps
`default_nettype none
module spi_register_access_slave_tb_top import spi_link_pkg::*;;
   localparam int unsigned HALF = SCK_HALF_CYC;
   logic       mclk, sys_rst, cmd_valid, cmd_wnr, cmd_ready, wr_take;
   logic       rd_valid, busy, reg_wr, reg_rd, sck_q;
   logic [6:0] cmd_addr, reg_addr;
   logic [7:0] cmd_len, wr_data, rd_data, reg_wdata, reg_rdata, mo_sh, mi_sh;
   logic [2:0] bitn, widx;
   logic [3:0] wp, rp;
   logic [7:0] regs [128];
   logic [7:0] fifo_mem [16];
   logic [7:0] wbuf [8];
   logic [7:0] ebuf [8];
   logic [7:0] mo_q [$];
   logic [7:0] mi_q [$];
   logic [7:0] rd_q [$];
   int         error_cnt, comparisons;
   ////////////////////////////////////////
   spi_link_if link_if ();
   spi_reg_master #(.HALF_CYC(HALF)) spi_reg_master_inst (.mclk(mclk), .sys_rst(sys_rst),
      .link(link_if.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_wnr(cmd_wnr),
      .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid), .busy(busy));
   spi_reg_slave #(.FIFO_ADDR(FIFO_ADDR_DEF)) spi_reg_slave_inst (.mclk(mclk),
      .sys_rst(sys_rst), .link(link_if.slave), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   spi_link_checker #(.HALF_CYC(HALF)) spi_link_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
      .sck(link_if.sck), .nss(link_if.nss), .mosi(link_if.mosi), .miso_o(link_if.miso_o),
      .miso_oe_n(link_if.miso_oe_n), .miso(link_if.miso));
   ////////////////////////////////////////
   // Register file and queue behind the slave
   assign wr_data   = wbuf[widx];
   assign reg_rdata = (reg_addr == FIFO_ADDR_DEF) ? fifo_mem[rp] : regs[reg_addr];
   always @(posedge mclk) begin
      if (wr_take) widx <= widx + 3'h1;
      if (rd_valid) rd_q.push_back(rd_data);
      if (reg_rd && reg_addr == FIFO_ADDR_DEF) rp <= rp + 4'h1;
      if (reg_wr && reg_addr == FIFO_ADDR_DEF) begin
         fifo_mem[wp] <= reg_wdata;
         wp           <= wp + 4'h1;
      end else if (reg_wr) begin
         regs[reg_addr] <= reg_wdata;
      end
      // Bytes seen on the wires: data in at rise, data out at end of high phase
      sck_q <= link_if.sck;
      if (link_if.nss) begin
         bitn <= 3'h0;
      end else if (link_if.sck && !sck_q) begin
         mo_sh <= {mo_sh[6:0], link_if.mosi};
      end else if (!link_if.sck && sck_q) begin
         mi_sh <= {mi_sh[6:0], link_if.miso};
         bitn  <= bitn + 3'h1;
         if (bitn == 3'h7) begin
            mo_q.push_back(mo_sh);
            mi_q.push_back({mi_sh[6:0], link_if.miso});
         end
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One frame through the master, then the wire bytes and results are compared
   task automatic frame(input logic wnr, input logic [6:0] a, input logic [7:0] n,
                        input logic ck_mi);
      int k;
      mo_q.delete();
      mi_q.delete();
      rd_q.delete();
      widx      <= 3'h0;
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_wnr   <= wnr;
      cmd_addr  <= a;
      cmd_len   <= n;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      repeat (2) @(posedge mclk);
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
         @(posedge mclk);
         k++;
      end
      if (k >= 5000) begin
         error_cnt++;
         $display("[ERR] %0t frame did not finish", $time);
      end
      repeat (3) @(posedge mclk);
      chk({7'h00, cmd_ready}, 8'h01);
      chk(mo_q[0], {wnr, a});
      chk(mi_q[0], 8'h00);
      for (k = 1; k <= n; k++) begin
         if (wnr) chk(mo_q[k], wbuf[k-1]);
         if (ck_mi) chk(mi_q[k], ebuf[k-1]);
         if (!wnr) chk(rd_q[k-1], ebuf[k-1]);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // Clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Hang guard
   initial begin
      #2_000_000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
   // Test sequence
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_wnr = 1'b0;
      cmd_addr = 7'h00;
      cmd_len = 8'h00;
      widx = 3'h0;
      wp = 4'h0;
      rp = 4'h0;
      bitn = 3'h0;
      sck_q = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      for (int i = 0; i < 128; i++) begin
         regs[i] = 8'(i) + 8'h40;
         if (i < 16) fifo_mem[i] = 8'h00;
         if (i < 8) wbuf[i] = 8'h00;
      end
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      wbuf[0] = 8'hA5;
      ebuf[0] = 8'h45;
      frame(1'b1, 7'h05, 8'h01, 1'b1);
      chk(regs[5], 8'hA5);
      for (int i = 0; i < 3; i++) begin
         wbuf[i] = 8'hC0 + 8'(i);
         ebuf[i] = 8'h50 + 8'(i);
      end
      frame(1'b1, 7'h10, 8'h03, 1'b1);
      ebuf[0] = 8'h4F;
      ebuf[1] = 8'hC0;
      ebuf[2] = 8'hC1;
      ebuf[3] = 8'hC2;
      frame(1'b0, 7'h0F, 8'h04, 1'b1);
      chk(regs[19], 8'h53);
      ebuf[0] = 8'hA5;
      frame(1'b0, 7'h05, 8'h01, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wbuf[i] = 8'h11 * 8'(i + 1);
         ebuf[i] = 8'h11 * 8'(i + 1);
      end
      frame(1'b1, FIFO_ADDR_DEF, 8'h03, 1'b0);
      chk(regs[1], 8'h41);
      chk(fifo_mem[2], 8'h33);
      frame(1'b0, FIFO_ADDR_DEF, 8'h03, 1'b1);
      frame(1'b0, 7'h05, 8'h00, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
